// *** logic/rcs_top.sv ***
/*
 Signal-strength readout and carrier sense with an AHB-Lite register slave.
 Assumes level samples from the receive chain in half-dB two's complement,
 one per i_smp_vld at twice the channel bandwidth, and one-cycle event
 pulses from the radio control and packet handler.
*/
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_top (
    input wire logic i_clk,
    input wire logic i_rst_b,
    // receive chain and radio control
    input wire logic i_smp_vld,
    input wire rcs_pkg::rcs_rssi_t i_smp,
    input wire logic i_rx_enter,
    input wire logic i_sync_det,
    input wire logic i_payload_end,
    // results
    output rcs_pkg::rcs_rssi_t o_rssi,
    output logic o_carrier,
    output logic o_sync_search_en,
    output logic o_pin_out,
    output logic o_cca_carrier,
    output logic o_rx_term_carrier,
    output rcs_pkg::rcs_rssi_t o_status_byte,
    output logic o_status_byte_vld,
    output logic o_irq,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp
);
    import rcs_pkg::*;

    // register state
    logic [31:0] ctrl_ff;
    logic [31:0] gain_ff;
    logic [3:0] output_pin_selector_ff;
    logic [`RCS_IRQ_W-1:0] irq_stat_ff;
    logic [`RCS_IRQ_W-1:0] irq_en_ff;

    // bus data phase
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] rdata_ff;

    // measurement state
    rcs_rssi_t rssi_ff;
    rcs_rssi_t sync_rssi_ff;
    rcs_rssi_t status_byte_ff;
    logic status_vld_ff;
    logic carrier_ff;
    rcs_rx_state_e state_ff;
    rcs_rx_state_e nxt_state;

    rcs_meas_if meas ();

    // control fields
    wire [1:0] filter_length = ctrl_ff[`RCS_CTRL_FLEN_LSB +: 2];
    wire [1:0] rel_step_select = ctrl_ff[`RCS_CTRL_REL_LSB +: 2];
    wire [3:0] abs_level_adjust = ctrl_ff[`RCS_CTRL_ADJ_LSB +: 4];
    wire status_bytes_append_en = ctrl_ff[`RCS_CTRL_APPEND_BIT];
    wire sync_cs_qualify = ctrl_ff[`RCS_CTRL_SYNCQ_BIT];
    wire [2:0] front_amp_gain_limit = gain_ff[`RCS_GAIN_LNA_LSB +: 3];
    wire [1:0] digital_gain_limit = gain_ff[`RCS_GAIN_DVGA_LSB +: 2];
    wire [2:0] channel_level_target = gain_ff[`RCS_GAIN_TGT_LSB +: 3];

    // bus decode
    wire addr_phase_w = i_hsel && i_htrans[1] && i_hready;
    wire wr_accept_w = addr_phase_w && i_hwrite;
    wire [7:0] rd_addr_w = i_haddr[7:0];
    wire wr_ctrl_w = wr_pend_ff && (wr_addr_ff == `RCS_OFF_CTRL);
    wire wr_gain_w = wr_pend_ff && (wr_addr_ff == `RCS_OFF_GAIN);
    wire wr_pin_w = wr_pend_ff && (wr_addr_ff == `RCS_OFF_PIN);
    wire wr_irq_clr_w = wr_pend_ff && (wr_addr_ff == `RCS_OFF_IRQ_CLR);
    wire wr_irq_en_w = wr_pend_ff && (wr_addr_ff == `RCS_OFF_IRQ_EN);

    // absolute threshold: gains lower it, adjust and target raise it
    rcs_thr_t tgt_off_w;
    always_comb begin
        case (channel_level_target)
            3'h0: tgt_off_w = `RCS_TGT0_HD;
            3'h1: tgt_off_w = `RCS_TGT1_HD;
            3'h2: tgt_off_w = `RCS_TGT2_HD;
            3'h3: tgt_off_w = `RCS_TGT3_HD;
            3'h4: tgt_off_w = `RCS_TGT4_HD;
            3'h5: tgt_off_w = `RCS_TGT5_HD;
            3'h6: tgt_off_w = `RCS_TGT6_HD;
            default: tgt_off_w = `RCS_TGT7_HD;
        endcase
    end

    // adjust code 1000 sits outside the +-7 dB range and turns the absolute test off
    wire abs_en_w = abs_level_adjust != `RCS_ADJ_DISABLE;
    wire rcs_thr_t adj_hd_w = {{5{abs_level_adjust[3]}}, abs_level_adjust, 1'b0};
    wire rcs_thr_t lna_hd_w = $signed({7'h0, front_amp_gain_limit}) * `RCS_LNA_STEP_HD;
    wire rcs_thr_t dvga_hd_w = $signed({8'h0, digital_gain_limit}) * `RCS_DVGA_STEP_HD;
    wire rcs_thr_t abs_thr_w = `RCS_THR_BASE + adj_hd_w - lna_hd_w - dvga_hd_w + tgt_off_w;

    // relative step in half-dB units
    logic signed [8:0] rel_step_w;
    always_comb begin
        case (rel_step_select)
            2'h1: rel_step_w = `RCS_REL_STEP1_HD;
            2'h2: rel_step_w = `RCS_REL_STEP2_HD;
            2'h3: rel_step_w = `RCS_REL_STEP3_HD;
            default: rel_step_w = 9'sh000;
        endcase
    end
    wire rel_en_w = rel_step_select != 2'h0;

    rcs_avg #(
        .ACC_W(14)
    ) u_avg (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_smp_vld(i_smp_vld),
        .i_smp(i_smp),
        .i_flen(filter_length),
        .meas(meas.src)
    );

    logic abs_flag_w;
    logic rel_flag_w;
    rcs_cs_detect u_det (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .meas(meas.snk),
        .i_abs_thr(abs_thr_w),
        .i_rel_step(rel_step_w),
        .o_abs_flag(abs_flag_w),
        .o_rel_flag(rel_flag_w)
    );

    // either enabled criterion holds the carrier
    wire nxt_carrier = (abs_en_w & abs_flag_w) | (rel_en_w & rel_flag_w);
    wire cs_rise_w = nxt_carrier & ~carrier_ff;
    wire cs_fall_w = ~nxt_carrier & carrier_ff;
    wire rssi_upd_w = meas.upd && (state_ff == RCS_TRACK);
    wire sync_cap_w = i_sync_det && (state_ff == RCS_TRACK) && !i_rx_enter;

    // receive entry wins over a sync in the same cycle
    always_comb begin
        case (state_ff)
            RCS_TRACK: nxt_state = sync_cap_w ? RCS_FROZEN : RCS_TRACK;
            RCS_FROZEN: nxt_state = i_rx_enter ? RCS_TRACK : RCS_FROZEN;
            default: nxt_state = RCS_TRACK;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= RCS_TRACK;
            rssi_ff <= 8'sh00;
            sync_rssi_ff <= 8'sh00;
            carrier_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            carrier_ff <= nxt_carrier;
            if (rssi_upd_w) begin
                rssi_ff <= meas.level;
            end
            if (sync_cap_w) begin
                sync_rssi_ff <= rssi_ff;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            status_byte_ff <= 8'sh00;
            status_vld_ff <= 1'b0;
        end else begin
            status_vld_ff <= i_payload_end && status_bytes_append_en;
            if (i_payload_end && status_bytes_append_en) begin
                status_byte_ff <= sync_rssi_ff;
            end
        end
    end

    // interrupt events; a new event in the clearing cycle survives
    wire [`RCS_IRQ_W-1:0] irq_evt_w = {sync_cap_w, rssi_upd_w, cs_fall_w, cs_rise_w};
    wire [`RCS_IRQ_W-1:0] irq_clr_w = wr_irq_clr_w ? i_hwdata[`RCS_IRQ_W-1:0] : '0;
    wire [`RCS_IRQ_W-1:0] nxt_irq_stat = irq_evt_w | (irq_stat_ff & ~irq_clr_w);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_stat_ff <= '0;
            irq_en_ff <= '0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_irq_en_w) begin
                irq_en_ff <= i_hwdata[`RCS_IRQ_W-1:0];
            end
        end
    end

    // configuration writes land in the data phase
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_ff <= `RCS_CTRL_RESET;
            gain_ff <= `RCS_GAIN_RESET;
            output_pin_selector_ff <= `RCS_PIN_RESET;
        end else begin
            if (wr_ctrl_w) begin
                ctrl_ff <= {22'h0, i_hwdata[9:0]};
            end
            if (wr_gain_w) begin
                gain_ff <= {24'h0, i_hwdata[7:0]};
            end
            if (wr_pin_w) begin
                output_pin_selector_ff <= i_hwdata[3:0];
            end
        end
    end

    // read data is sampled in the address phase so it sits in a flop for the data phase
    logic [31:0] rd_mux_w;
    always_comb begin
        case (rd_addr_w)
            `RCS_OFF_CTRL: rd_mux_w = ctrl_ff;
            `RCS_OFF_GAIN: rd_mux_w = gain_ff;
            `RCS_OFF_PIN: rd_mux_w = {28'h0, output_pin_selector_ff};
            `RCS_OFF_STAT: rd_mux_w = {22'h0, state_ff == RCS_FROZEN, carrier_ff, rssi_ff};
            `RCS_OFF_IRQ_STAT: rd_mux_w = {28'h0, irq_stat_ff};
            `RCS_OFF_IRQ_EN: rd_mux_w = {28'h0, irq_en_ff};
            `RCS_OFF_SYNC_RSSI: rd_mux_w = {24'h0, sync_rssi_ff};
            default: rd_mux_w = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= wr_accept_w;
            if (addr_phase_w) begin
                wr_addr_ff <= i_haddr[7:0];
                rdata_ff <= i_hwrite ? 32'h0000_0000 : rd_mux_w;
            end
        end
    end

    assign o_hrdata = rdata_ff;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    assign o_rssi = rssi_ff;
    assign o_carrier = carrier_ff;
    assign o_sync_search_en = !sync_cs_qualify || carrier_ff;
    assign o_pin_out = (output_pin_selector_ff == `RCS_PIN_SEL_CARRIER) && carrier_ff;
    assign o_cca_carrier = carrier_ff;
    assign o_rx_term_carrier = carrier_ff;
    assign o_status_byte = status_byte_ff;
    assign o_status_byte_vld = status_vld_ff;
    assign o_irq = |(irq_stat_ff & irq_en_ff);
endmodule

// *** include/rcs_consts.svh ***
/*
 Constants of the signal-strength and carrier-sense block: register offsets,
 field positions, reset values and threshold figures.
 Assumes it is included by its bare name by the logic modules and the bench.
*/
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// register byte offsets
`define RCS_OFF_CTRL 8'h00
`define RCS_OFF_GAIN 8'h04
`define RCS_OFF_PIN 8'h08
`define RCS_OFF_STAT 8'h0c
`define RCS_OFF_IRQ_STAT 8'h10
`define RCS_OFF_IRQ_CLR 8'h14
`define RCS_OFF_IRQ_EN 8'h18
`define RCS_OFF_SYNC_RSSI 8'h1c

// control register fields
`define RCS_CTRL_FLEN_LSB 0
`define RCS_CTRL_REL_LSB 2
`define RCS_CTRL_ADJ_LSB 4
`define RCS_CTRL_APPEND_BIT 8
`define RCS_CTRL_SYNCQ_BIT 9
`define RCS_CTRL_RESET 32'h0000_0000

// gain register fields
`define RCS_GAIN_LNA_LSB 0
`define RCS_GAIN_DVGA_LSB 3
`define RCS_GAIN_TGT_LSB 5
`define RCS_GAIN_RESET 32'h0000_0060

// pin selector code that routes the carrier flag out
`define RCS_PIN_SEL_CARRIER 4'he
`define RCS_PIN_RESET 4'h0

// interrupt event bits
`define RCS_IRQ_CS_RISE 0
`define RCS_IRQ_CS_FALL 1
`define RCS_IRQ_UPDATE 2
`define RCS_IRQ_SYNC 3
`define RCS_IRQ_W 4

// averaging: base block of 8 samples, times 2^filter_length
`define RCS_AVG_BASE_LOG2 3

// threshold figures in half-dB units
`define RCS_THR_BASE 10'sh000
`define RCS_LNA_STEP_HD 10'sh006
`define RCS_DVGA_STEP_HD 10'sh00c
`define RCS_HYST_HD 10'sh002
`define RCS_ADJ_DISABLE 4'h8
`define RCS_REL_STEP1_HD 9'sh00c
`define RCS_REL_STEP2_HD 9'sh014
`define RCS_REL_STEP3_HD 9'sh01c

// level target code offsets from the 33 dB default, half-dB units
`define RCS_TGT0_HD 10'sh3ee
`define RCS_TGT1_HD 10'sh3f4
`define RCS_TGT2_HD 10'sh3fa
`define RCS_TGT3_HD 10'sh000
`define RCS_TGT4_HD 10'sh006
`define RCS_TGT5_HD 10'sh00a
`define RCS_TGT6_HD 10'sh00e
`define RCS_TGT7_HD 10'sh012

`endif

// *** include/rcs_pkg.sv ***
/*
 Types shared by the signal-strength and carrier-sense modules.
 Assumes nothing of its surroundings.
*/
package rcs_pkg;
    typedef logic signed [7:0] rcs_rssi_t;
    typedef logic signed [9:0] rcs_thr_t;
    typedef enum logic [1:0] {
        RCS_TRACK = 2'b01,
        RCS_FROZEN = 2'b10
    } rcs_rx_state_e;
endpackage

// *** include/rcs_meas_if.sv ***
/*
 Carrier for averaged strength samples between the averager and its users.
 Assumes one clock; upd is a one-cycle strobe with level valid beside it.
*/
`timescale 1ns/1ps
interface rcs_meas_if;
    logic signed [7:0] level;
    logic upd;
    modport src (output level, output upd);
    modport snk (input level, input upd);
endinterface

// *** logic/rcs_avg.sv ***
/*
 Averager: sums 8*2^filter_length level samples and emits their mean.
 Assumes input samples arrive at twice the channel bandwidth, one per strobe.
*/
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_avg #(
    parameter int ACC_W = 14
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_smp_vld,
    input wire rcs_pkg::rcs_rssi_t i_smp,
    input wire logic [1:0] i_flen,
    rcs_meas_if.src meas
);
    import rcs_pkg::*;

    logic [5:0] cnt_ff;
    logic signed [ACC_W-1:0] acc_ff;
    rcs_rssi_t level_ff;
    logic upd_ff;

    wire [2:0] shift_w = 3'(`RCS_AVG_BASE_LOG2) + {1'b0, i_flen};
    wire [5:0] last_w = 6'((7'h1 << shift_w) - 7'h1);
    wire block_end_w = i_smp_vld && (cnt_ff >= last_w);
    wire signed [ACC_W-1:0] sum_w = acc_ff + ACC_W'(i_smp);
    wire signed [ACC_W-1:0] mean_w = sum_w >>> shift_w;

    // a shorter filter length taking effect mid-block ends that block at the new length, or on the next sample if the count is already past it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_ff <= 6'h00;
            acc_ff <= '0;
            level_ff <= 8'sh00;
            upd_ff <= 1'b0;
        end else begin
            upd_ff <= block_end_w;
            if (block_end_w) begin
                cnt_ff <= 6'h00;
                acc_ff <= '0;
                level_ff <= mean_w[7:0];
            end else if (i_smp_vld) begin
                cnt_ff <= cnt_ff + 6'h01;
                acc_ff <= sum_w;
            end
        end
    end

    assign meas.level = level_ff;
    assign meas.upd = upd_ff;
endmodule

// *** logic/rcs_cs_detect.sv ***
/*
 Carrier detection from averaged strength: absolute level with hysteresis
 and relative step between consecutive samples.
 Assumes thresholds are quasi-static and are sampled on each update.
*/
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_cs_detect (
    input wire logic i_clk,
    input wire logic i_rst_b,
    rcs_meas_if.snk meas,
    input wire rcs_pkg::rcs_thr_t i_abs_thr,
    input wire logic signed [8:0] i_rel_step,
    output logic o_abs_flag,
    output logic o_rel_flag
);
    import rcs_pkg::*;

    rcs_rssi_t prev_ff;
    logic have_prev_ff;
    logic abs_ff;
    logic rel_ff;

    wire rcs_thr_t lvl_w = {{2{meas.level[7]}}, meas.level};
    wire abs_set_w = lvl_w > i_abs_thr;
    wire abs_clr_w = lvl_w < (i_abs_thr - `RCS_HYST_HD);
    wire signed [8:0] diff_w = {meas.level[7], meas.level} - {prev_ff[7], prev_ff};
    wire rel_set_w = have_prev_ff && (diff_w >= i_rel_step);
    wire rel_clr_w = have_prev_ff && (diff_w <= -i_rel_step);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prev_ff <= 8'sh00;
            have_prev_ff <= 1'b0;
            abs_ff <= 1'b0;
            rel_ff <= 1'b0;
        end else if (meas.upd) begin
            prev_ff <= meas.level;
            have_prev_ff <= 1'b1;
            abs_ff <= abs_set_w | (abs_ff & ~abs_clr_w);
            rel_ff <= rel_set_w | (rel_ff & ~rel_clr_w);
        end
    end

    assign o_abs_flag = abs_ff;
    assign o_rel_flag = rel_ff;
endmodule

// *** sim/rcs_rx_model.sv ***
/* Receive chain stand-in: bursts of equal level samples on command.
   Assumes the bench pulses i_go with level, count and pacing. */
`timescale 1ns/1ps
module rcs_rx_model (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_go,
    input wire logic i_slow,
    input wire logic [6:0] i_cnt,
    input wire rcs_pkg::rcs_rssi_t i_lvl,
    output logic o_smp_vld,
    output rcs_pkg::rcs_rssi_t o_smp,
    output logic o_busy
);
    import rcs_pkg::*;
    logic [6:0] cnt_ff;
    logic tog_ff;
    rcs_rssi_t lvl_ff;
    assign o_busy = (cnt_ff != 7'h00) || o_smp_vld;
    // idle bus carries the inverse, so a stale level never passes for a sample
    assign o_smp = o_smp_vld ? lvl_ff : ~lvl_ff;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_ff <= 7'h00;
            tog_ff <= 1'b0;
            lvl_ff <= 8'sh00;
            o_smp_vld <= 1'b0;
        end else begin
            tog_ff <= ~tog_ff;
            o_smp_vld <= 1'b0;
            if (i_go) begin
                cnt_ff <= i_cnt;
                lvl_ff <= i_lvl;
            end else if (cnt_ff != 7'h00 && !(i_slow && tog_ff)) begin
                o_smp_vld <= 1'b1;
                cnt_ff <= cnt_ff - 7'h01;
            end
        end
    end
endmodule

// *** sim/rcs_top_properties.sv ***
/* Concurrent checks on the ports of rcs_top.
   Assumes one clock and the asynchronous active-low reset of the top. */
`timescale 1ns/1ps
module rcs_top_props (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_smp_vld,
    input wire logic i_rx_enter,
    input wire logic i_sync_det,
    input wire logic i_payload_end,
    input wire rcs_pkg::rcs_rssi_t o_rssi,
    input wire logic o_carrier,
    input wire logic o_sync_search_en,
    input wire logic o_pin_out,
    input wire logic o_cca_carrier,
    input wire logic o_rx_term_carrier,
    input wire rcs_pkg::rcs_rssi_t o_status_byte,
    input wire logic o_status_byte_vld
);
    import rcs_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic frz_ff;
    rcs_rssi_t cap_ff;
    // shadow of the freeze state; a sync while frozen must not recapture
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            frz_ff <= 1'b0;
            cap_ff <= 8'sh00;
        end else if (i_rx_enter) begin
            frz_ff <= 1'b0;
        end else if (i_sync_det && !frz_ff) begin
            frz_ff <= 1'b1;
            cap_ff <= o_rssi;
        end
    end
    property p_pin_route; o_pin_out |-> o_carrier; endproperty
    a_pin_route: assert property (p_pin_route) else $error("pin out high without carrier");
    property p_copies; o_cca_carrier == o_carrier && o_rx_term_carrier == o_carrier; endproperty
    a_copies: assert property (p_copies) else $error("carrier copies differ");
    property p_search; !o_sync_search_en |-> !o_carrier; endproperty
    a_search: assert property (p_search) else $error("sync search blocked with carrier");
    property p_rssi_cause; $changed(o_rssi) |-> $past(i_smp_vld, 2); endproperty
    a_rssi_cause: assert property (p_rssi_cause) else $error("strength moved off a block end");
    property p_frozen; frz_ff && $past(frz_ff) |-> $stable(o_rssi); endproperty
    a_frozen: assert property (p_frozen) else $error("strength moved while frozen");
    property p_vld_cause; o_status_byte_vld |-> $past(i_payload_end); endproperty
    a_vld_cause: assert property (p_vld_cause) else $error("status byte without payload end");
    property p_byte_hold; $changed(o_status_byte) |-> o_status_byte_vld; endproperty
    a_byte_hold: assert property (p_byte_hold) else $error("status byte changed silently");
    property p_byte_val; o_status_byte_vld |-> o_status_byte == cap_ff; endproperty
    a_byte_val: assert property (p_byte_val) else $error("status byte not the sync strength");
endmodule
bind rcs_top rcs_top_props u_props (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_smp_vld(i_smp_vld),
    .i_rx_enter(i_rx_enter), .i_sync_det(i_sync_det), .i_payload_end(i_payload_end), .o_rssi(o_rssi),
    .o_carrier(o_carrier), .o_sync_search_en(o_sync_search_en), .o_pin_out(o_pin_out),
    .o_cca_carrier(o_cca_carrier), .o_rx_term_carrier(o_rx_term_carrier), .o_status_byte(o_status_byte),
    .o_status_byte_vld(o_status_byte_vld));

// *** sim/tb_rssi_carrier_sense.sv ***
/* Self-checking bench for rcs_top: a table of level blocks, then hand tests.
   Assumes rcs_rx_model feeds samples and the bench is the only bus master. */
`timescale 1ns/1ps
`include "rcs_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_rssi_carrier_sense;
    import rcs_pkg::*;
    typedef struct packed {logic [9:0] ctrl; logic [7:0] gain; rcs_rssi_t lvl; logic car;} rcs_row_s;
    logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, slow = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [1:0] htrans = 2'h0;
    logic [6:0] cnt = 7'h00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    rcs_rssi_t lvl = 8'sh00, smp, rssi, sbyte, prev;
    logic vld, busy, car, sse, pin, cca, rxt, svld, irq, hready, hresp;
    logic [9:0] raw;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    logic [7:0] ra[6] = '{`RCS_OFF_CTRL, `RCS_OFF_GAIN, `RCS_OFF_PIN, `RCS_OFF_STAT, `RCS_OFF_IRQ_EN, 8'h40};
    logic [31:0] rv[6] = '{32'h0, 32'h60, 32'h0, 32'h0, 32'h0, 32'h0};
    // rows run in order: hysteresis and step rows lean on the row before
    rcs_row_s rows[16] = '{
        '{10'h000, 8'h60, 8'sh01, 1'b1}, '{10'h000, 8'h60, 8'shff, 1'b1},
        '{10'h000, 8'h60, 8'shfd, 1'b0}, '{10'h030, 8'h60, 8'sh06, 1'b0},
        '{10'h030, 8'h60, 8'sh07, 1'b1}, '{10'h090, 8'h69, 8'shdf, 1'b1},
        '{10'h090, 8'h69, 8'shdd, 1'b0}, '{10'h001, 8'h00, 8'shef, 1'b1},
        '{10'h080, 8'h60, 8'sh32, 1'b0}, '{10'h084, 8'h60, 8'sh3e, 1'b1},
        '{10'h084, 8'h60, 8'sh33, 1'b1}, '{10'h084, 8'h60, 8'sh27, 1'b0},
        '{10'h088, 8'h60, 8'sh3a, 1'b0}, '{10'h088, 8'h60, 8'sh4e, 1'b1},
        '{10'h08e, 8'h60, 8'sh32, 1'b0}, '{10'h003, 8'h60, 8'sh05, 1'b1}};
    rcs_top DUT (.i_clk(clk), .i_rst_b(rst_b), .i_smp_vld(vld), .i_smp(smp), .i_rx_enter(ev[0]),
        .i_sync_det(ev[1]), .i_payload_end(ev[2]), .o_rssi(rssi), .o_carrier(car), .o_sync_search_en(sse),
        .o_pin_out(pin), .o_cca_carrier(cca), .o_rx_term_carrier(rxt), .o_status_byte(sbyte),
        .o_status_byte_vld(svld), .o_irq(irq), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp));
    rcs_rx_model u_src (.i_clk(clk), .i_rst_b(rst_b), .i_go(go), .i_slow(slow), .i_cnt(cnt), .i_lvl(lvl),
        .o_smp_vld(vld), .o_smp(smp), .o_busy(busy));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic send(input rcs_rssi_t v, input logic [6:0] n, input logic s);
        @(posedge clk);
        go <= 1'b1;
        lvl <= v;
        cnt <= n;
        slow <= s;
        @(posedge clk);
        go <= 1'b0;
        do begin @(posedge clk); #1; end while (busy === 1'b1);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 3'h0;
        #1;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        prev = 8'sh00;
        foreach (rows[i]) begin
            ahb(1'b1, `RCS_OFF_CTRL, {22'h0, rows[i].ctrl});
            ahb(1'b1, `RCS_OFF_GAIN, {24'h0, rows[i].gain});
            send(rows[i].lvl, 7'(8 << rows[i].ctrl[1:0]), rows[i].ctrl[0]);
            `CHK("rssi early", prev, rssi)
            @(posedge clk);
            #1;
            `CHK("rssi", rows[i].lvl, rssi)
            // carrier flag trails the strength by one cycle
            @(posedge clk);
            #1;
            `CHK("carrier", rows[i].car, car)
            `CHK("cca", rows[i].car, cca)
            `CHK("rx term", rows[i].car, rxt)
            ahb(1'b0, `RCS_OFF_STAT, 32'h0);
            `CHK("stat", {23'h0, rows[i].car, rows[i].lvl}, rd)
            raw = {2'b00, rd[7:0]} - ((rd[7:0] >= 8'h80) ? 10'h100 : 10'h000);
            `CHK("raw", {{2{rows[i].lvl[7]}}, rows[i].lvl}, raw)
            prev = rows[i].lvl;
        end
        ahb(1'b1, `RCS_OFF_PIN, 32'he);
        #1;
        `CHK("pin on", 1'b1, pin)
        ahb(1'b1, `RCS_OFF_PIN, 32'hd);
        #1;
        `CHK("pin off", 1'b0, pin)
        ahb(1'b1, `RCS_OFF_CTRL, 32'h300);
        #1;
        `CHK("search on", 1'b1, sse)
        send(8'shfa, 7'h08, 1'b0);
        settle();
        `CHK("search off", 1'b0, sse)
        ahb(1'b1, `RCS_OFF_IRQ_CLR, 32'hf);
        ahb(1'b1, `RCS_OFF_IRQ_EN, 32'h1);
        #1;
        `CHK("irq idle", 1'b0, irq)
        send(8'sh0a, 7'h08, 1'b0);
        settle();
        ahb(1'b0, `RCS_OFF_IRQ_STAT, 32'h0);
        `CHK("irq stat", 1'b1, rd[0])
        `CHK("irq rise", 1'b1, irq)
        ahb(1'b1, `RCS_OFF_IRQ_EN, 32'h0);
        #1;
        `CHK("irq masked", 1'b0, irq)
        ahb(1'b1, `RCS_OFF_IRQ_EN, 32'h1);
        #1;
        `CHK("irq unmasked", 1'b1, irq)
        ahb(1'b1, `RCS_OFF_IRQ_CLR, 32'h1);
        #1;
        `CHK("irq cleared", 1'b0, irq)
        pulse(3'h2);
        send(8'sh14, 7'h08, 1'b0);
        settle();
        `CHK("frozen", 8'sh0a, rssi)
        ahb(1'b0, `RCS_OFF_SYNC_RSSI, 32'h0);
        `CHK("sync rssi", 32'h0a, rd)
        pulse(3'h4);
        `CHK("byte vld", 1'b1, svld)
        `CHK("byte", 8'sh0a, sbyte)
        pulse(3'h1);
        send(8'sh14, 7'h08, 1'b0);
        settle();
        `CHK("tracking", 8'sh14, rssi)
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        `CHK("rssi reset", 8'sh00, rssi)
        `CHK("byte reset", 8'sh00, sbyte)
        ahb(1'b1, `RCS_OFF_STAT, 32'h3ff);
        foreach (ra[i]) begin
            ahb(1'b0, ra[i], 32'h0);
            `CHK("reg", rv[i], rd)
        end
        ahb(1'b1, `RCS_OFF_GAIN, 32'h7f);
        send(8'shc4, 7'h08, 1'b0);
        settle();
        `CHK("full gain", 1'b1, car)
        // raise the level the recommended way: amplifier limit first
        ahb(1'b1, `RCS_OFF_GAIN, 32'h78);
        send(8'shc4, 7'h08, 1'b0);
        settle();
        `CHK("amp limit cut", 1'b0, car)
        tally_and_finish();
    end
endmodule
